// [shared/debug_claim_lock_cfg.svh]
// offsets, field positions and reset values of the claim and lock registers
// assumes a 4 KB debug window, byte offsets on address bits [11:0]
`ifndef DEBUG_CLAIM_LOCK_CFG_SVH
`define DEBUG_CLAIM_LOCK_CFG_SVH

// ==========================================================
// register byte offsets inside the debug window
`define DCL_OFS_CLAIM_SET   12'hfa0
`define DCL_OFS_CLAIM_CLEAR 12'hfa4
`define DCL_OFS_LOCK_KEY    12'hfb0
`define DCL_OFS_LOCK_STATUS 12'hfb4
`define DCL_OFS_MSB         11

// ==========================================================
// address bit that marks an access by the external debugger
`define DCL_EXT_BIT         31

// ==========================================================
// lock status field positions
`define DCL_LSR_IMPL_BIT    0
`define DCL_LSR_LOCKED_BIT  1
`define DCL_LSR_WIDE_BIT    2

// ==========================================================
// key and reset values
`define DCL_UNLOCK_KEY      32'hc5acce55
`define DCL_KEY_RST         32'h00000000
`define DCL_LOCKED_RST      1'b1
`define DCL_LSR_IMPL_VAL    1'b1
`define DCL_LSR_WIDE_VAL    1'b0
`define DCL_CLAIM_MAX       8

`endif

// [shared/debug_claim_lock_pkg.sv]
// types shared by the claim and lock register files
// assumes the constants header is compiled alongside
package debug_claim_lock_pkg;

	// ==========================================================
	// register selected by the current bus address
	typedef enum {
		SEL_NONE,
		SEL_CLAIM_SET,
		SEL_CLAIM_CLEAR,
		SEL_LOCK_KEY,
		SEL_LOCK_STATUS
	} reg_sel_t;

endpackage : debug_claim_lock_pkg

// [core/claim_tag_bank.sv]
// claim tag storage: one flop per tag, set and clear by write-one masks
// assumes the caller has already applied address decode and lock gating
`include "debug_claim_lock_cfg.svh"

module claim_tag_bank #(
	parameter int NUM_CLAIMS = 8
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	input  wire logic                  i_set_we,
	input  wire logic                  i_clear_we,
	input  wire logic [NUM_CLAIMS-1:0] i_wdata,
	output logic      [NUM_CLAIMS-1:0] o_tags
);

	// ==========================================================
	// elaboration check
	generate
		if (NUM_CLAIMS < 1 || NUM_CLAIMS > `DCL_CLAIM_MAX) begin : g_bad_width
			$error("claim_tag_bank: NUM_CLAIMS must be 1 to 8");
		end
	endgenerate

	// ==========================================================
	// per-tag flops
	genvar b;
	generate
		for (b = 0; b < NUM_CLAIMS; b++) begin : g_tag
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					o_tags[b] <= 1'b0;
				end else if (i_set_we && i_wdata[b]) begin
					o_tags[b] <= 1'b1;
				end else if (i_clear_we && i_wdata[b]) begin
					o_tags[b] <= 1'b0;
				end
				// a zero data bit falls through and keeps the tag
			end
		end
	endgenerate

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	tag_set_a: assert property (
		i_set_we |=> o_tags == ($past(o_tags) | $past(i_wdata)))
		else $error("claim set did not or in the written ones");

	tag_clear_a: assert property (
		i_clear_we && !i_set_we |=> o_tags == ($past(o_tags) & ~$past(i_wdata)))
		else $error("claim clear did not remove the written ones");

	tag_hold_a: assert property (
		!i_set_we && !i_clear_we |=> $stable(o_tags))
		else $error("claim tags changed without a write");

	tag_reset_a: assert property (@(posedge i_clk) disable iff (1'b0)
		i_srst |=> o_tags == '0)
		else $error("claim tags not zero after reset");

endmodule : claim_tag_bank

// [core/debug_claim_and_lock_regs.sv]
// claim tag and software lock registers on the debug APB port
// assumes an APB master on i_clk; address bit 31 high marks the external debugger
//
// How it works
// - a write of ones to claim set sets those claim tags
// - zero data bits leave the matching claim tags as they are
// - reading claim set always returns all eight tag bits as ones
// - bits 31 to 8 of both claim registers read zero; master writes zero
// - a write of ones to claim clear clears those claim tags
// - reading claim clear returns the current claim tags
// - claim tags are zero after reset
// - only the full 32-bit key written to lock key opens the lock
// - any other value software writes to lock key closes the lock again
// - while locked, software writes to protected registers are dropped; external writes still land
// - lock key resets to zero and debug reset sets the lock
// - lock status bit one shows locked as one, open as zero
// - lock status bit two reads zero and bit zero reads one
// - lock status reads zero for external accesses
// - the lock survives core reset; only debug reset touches it
`include "debug_claim_lock_cfg.svh"

module debug_claim_and_lock_regs #(
	parameter int NUM_CLAIMS = 8
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	input  wire logic                  i_dbg_srst,
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [31:0]           i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic      [31:0]           o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	output logic      [NUM_CLAIMS-1:0] o_claim_tags,
	output logic                       o_locked,
	output logic                       o_write_dropped
);

	// ==========================================================
	// elaboration check
	generate
		if (NUM_CLAIMS < 1 || NUM_CLAIMS > `DCL_CLAIM_MAX) begin : g_bad_width
			$error("debug_claim_and_lock_regs: NUM_CLAIMS must be 1 to 8");
		end
	endgenerate

	// ==========================================================
	// address decode
	function automatic debug_claim_lock_pkg::reg_sel_t decode_ofs(
		input logic [`DCL_OFS_MSB:0] ofs
	);
		debug_claim_lock_pkg::reg_sel_t sel;
		sel = debug_claim_lock_pkg::SEL_NONE;
		if (ofs == `DCL_OFS_CLAIM_SET) begin
			sel = debug_claim_lock_pkg::SEL_CLAIM_SET;
		end else if (ofs == `DCL_OFS_CLAIM_CLEAR) begin
			sel = debug_claim_lock_pkg::SEL_CLAIM_CLEAR;
		end else if (ofs == `DCL_OFS_LOCK_KEY) begin
			sel = debug_claim_lock_pkg::SEL_LOCK_KEY;
		end else if (ofs == `DCL_OFS_LOCK_STATUS) begin
			sel = debug_claim_lock_pkg::SEL_LOCK_STATUS;
		end
		return sel;
	endfunction : decode_ofs

	// true for registers whose writes the lock guards
	function automatic logic is_protected(
		input debug_claim_lock_pkg::reg_sel_t sel
	);
		return sel == debug_claim_lock_pkg::SEL_CLAIM_SET ||
		       sel == debug_claim_lock_pkg::SEL_CLAIM_CLEAR;
	endfunction : is_protected

	debug_claim_lock_pkg::reg_sel_t sel;
	logic                           ext;
	logic                           setup;
	logic                           access;
	logic                           wr;
	logic                           rd_setup;
	logic                           protect_ok;
	logic                           claim_set_we;
	logic                           claim_clear_we;
	logic                           key_we;
	logic                           drop;
	logic [31:0]                    lock_key;
	logic [31:0]                    next_prdata;

	assign sel      = decode_ofs(i_paddr[`DCL_OFS_MSB:0]);
	assign ext      = i_paddr[`DCL_EXT_BIT];
	assign setup    = i_psel && !i_penable;
	assign access   = i_psel && i_penable;
	assign wr       = access && i_pwrite;
	assign rd_setup = setup && !i_pwrite;

	// the external debugger is never held off by the software lock
	assign protect_ok = ext || !o_locked;

	assign claim_set_we   = wr && sel == debug_claim_lock_pkg::SEL_CLAIM_SET && protect_ok;
	assign claim_clear_we = wr && sel == debug_claim_lock_pkg::SEL_CLAIM_CLEAR && protect_ok;

	// lock key is never gated by the lock itself, or it could not be reopened
	// external writes to it are dropped: their outcome is left undefined
	assign key_we = wr && sel == debug_claim_lock_pkg::SEL_LOCK_KEY && !ext;

	assign drop = wr && is_protected(sel) && !protect_ok;

	// ==========================================================
	// bus handshake: zero wait states, no error answer
	assign o_pready  = 1'b1;
	// unmapped offsets read zero and ignore writes rather than fault
	assign o_pslverr = 1'b0;

	// ==========================================================
	// claim tags
	claim_tag_bank #(
		.NUM_CLAIMS (NUM_CLAIMS)
	) u_claims (
		.i_clk      (i_clk),
		.i_srst     (i_srst || i_dbg_srst),
		.i_set_we   (claim_set_we),
		.i_clear_we (claim_clear_we),
		.i_wdata    (i_pwdata[NUM_CLAIMS-1:0]), // upper data bits are ignored
		.o_tags     (o_claim_tags)
	);

	// ==========================================================
	// lock: kept in the debug domain, so only debug reset resets it
	always_ff @(posedge i_clk) begin
		if (i_dbg_srst) begin
			lock_key <= `DCL_KEY_RST;
			o_locked <= `DCL_LOCKED_RST;
		end else if (key_we) begin
			lock_key <= i_pwdata;
			o_locked <= (i_pwdata != `DCL_UNLOCK_KEY);
		end
		// core reset deliberately absent here
	end

	// ==========================================================
	// dropped write indication
	always_ff @(posedge i_clk) begin
		if (i_srst || i_dbg_srst) begin
			o_write_dropped <= 1'b0;
		end else begin
			o_write_dropped <= drop;
		end
	end

	// ==========================================================
	// read data: sampled in the setup phase, shown in the access phase
	always_comb begin
		next_prdata = '0;
		case (sel)
			debug_claim_lock_pkg::SEL_CLAIM_SET: begin
				next_prdata[NUM_CLAIMS-1:0] = '1;
			end
			debug_claim_lock_pkg::SEL_CLAIM_CLEAR: begin
				next_prdata[NUM_CLAIMS-1:0] = o_claim_tags;
			end
			debug_claim_lock_pkg::SEL_LOCK_STATUS: begin
				if (!ext) begin
					next_prdata[`DCL_LSR_IMPL_BIT]   = `DCL_LSR_IMPL_VAL;
					next_prdata[`DCL_LSR_LOCKED_BIT] = o_locked;
					next_prdata[`DCL_LSR_WIDE_BIT]   = `DCL_LSR_WIDE_VAL;
				end
				// external reads see all zeros
			end
			default: begin
				next_prdata = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_prdata <= '0;
		end else if (rd_setup) begin
			o_prdata <= next_prdata;
		end else if (access) begin
			// clear after the transfer so stale data never lingers on the bus
			o_prdata <= '0;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst || i_dbg_srst);

	sequence s_read_setup(debug_claim_lock_pkg::reg_sel_t r, logic x);
		rd_setup && sel == r && ext == x;
	endsequence

	sequence s_sw_key_write(logic [31:0] v);
		wr && sel == debug_claim_lock_pkg::SEL_LOCK_KEY && !ext && i_pwdata == v;
	endsequence

	sequence s_sw_claim_set;
		wr && sel == debug_claim_lock_pkg::SEL_CLAIM_SET && !ext;
	endsequence

	claim_set_read_a: assert property (
		s_read_setup(debug_claim_lock_pkg::SEL_CLAIM_SET, 1'b0) or
		s_read_setup(debug_claim_lock_pkg::SEL_CLAIM_SET, 1'b1)
		|=> o_prdata[NUM_CLAIMS-1:0] == '1)
		else $error("claim set read is not all ones");

	claim_upper_zero_a: assert property (
		rd_setup && is_protected(sel)
		|=> o_prdata[31:NUM_CLAIMS] == '0)
		else $error("claim register upper bits not zero");

	claim_clear_read_a: assert property (
		rd_setup && sel == debug_claim_lock_pkg::SEL_CLAIM_CLEAR
		|=> o_prdata[NUM_CLAIMS-1:0] == $past(o_claim_tags))
		else $error("claim clear read does not show the tags");

	unlock_then_claim_a: assert property (
		s_sw_key_write(`DCL_UNLOCK_KEY) ##[2:3] s_sw_claim_set
		|=> o_claim_tags == ($past(o_claim_tags) | $past(i_pwdata[NUM_CLAIMS-1:0])))
		else $error("claim set refused right after unlock");

	key_opens_a: assert property (
		s_sw_key_write(`DCL_UNLOCK_KEY) |=> !o_locked && lock_key == `DCL_UNLOCK_KEY)
		else $error("full key did not open the lock");

	wrong_key_locks_a: assert property (
		key_we && i_pwdata != `DCL_UNLOCK_KEY |=> o_locked)
		else $error("wrong key left the lock open");

	locked_claim_held_a: assert property (
		o_locked && !ext && wr && is_protected(sel)
		|=> $stable(o_claim_tags) && o_write_dropped)
		else $error("locked write changed a claim tag");

	lock_reset_a: assert property (@(posedge i_clk) disable iff (1'b0)
		i_dbg_srst |=> o_locked && lock_key == `DCL_KEY_RST)
		else $error("debug reset did not set the lock");

	locked_bit_read_a: assert property (
		s_read_setup(debug_claim_lock_pkg::SEL_LOCK_STATUS, 1'b0)
		|=> o_prdata[`DCL_LSR_LOCKED_BIT] == $past(o_locked))
		else $error("lock status locked bit wrong");

	status_fixed_bits_a: assert property (
		s_read_setup(debug_claim_lock_pkg::SEL_LOCK_STATUS, 1'b0)
		|=> o_prdata[`DCL_LSR_IMPL_BIT] && !o_prdata[`DCL_LSR_WIDE_BIT] && o_prdata[31:3] == '0)
		else $error("lock status fixed bits wrong");

	ext_key_ignored_a: assert property (
		wr && ext && sel == debug_claim_lock_pkg::SEL_LOCK_KEY
		|=> $stable(o_locked) && $stable(lock_key))
		else $error("external key write changed the lock");

	ext_status_zero_a: assert property (
		s_read_setup(debug_claim_lock_pkg::SEL_LOCK_STATUS, 1'b1) |=> o_prdata == '0)
		else $error("external lock status read not zero");

	lock_survives_core_a: assert property (@(posedge i_clk) disable iff (i_dbg_srst)
		i_srst |=> $stable(o_locked) && $stable(lock_key))
		else $error("core reset disturbed the lock");

	key_reachable_a: assert property (
		o_locked ##0 s_sw_key_write(`DCL_UNLOCK_KEY) ##[1:2]
		s_read_setup(debug_claim_lock_pkg::SEL_LOCK_STATUS, 1'b0)
		|=> o_prdata[`DCL_LSR_LOCKED_BIT] == 1'b0)
		else $error("lock could not be opened or observed");

	answer_one_cycle_a: assert property (
		rd_setup ##1 access |-> o_pready && !o_pslverr)
		else $error("access phase not completed in one cycle");

	sw_claim_set_a: assert property (
		s_sw_claim_set && !o_locked
		|=> o_claim_tags == ($past(o_claim_tags) | $past(i_pwdata[NUM_CLAIMS-1:0])))
		else $error("software claim set did not set the written ones");

	ext_claim_set_a: assert property (
		wr && ext && sel == debug_claim_lock_pkg::SEL_CLAIM_SET
		|=> o_claim_tags == ($past(o_claim_tags) | $past(i_pwdata[NUM_CLAIMS-1:0])))
		else $error("external claim set did not set the written ones");

	sw_claim_clear_a: assert property (
		wr && sel == debug_claim_lock_pkg::SEL_CLAIM_CLEAR && !ext && !o_locked
		|=> o_claim_tags == ($past(o_claim_tags) & ~$past(i_pwdata[NUM_CLAIMS-1:0])))
		else $error("software claim clear did not clear the written ones");

	ext_claim_clear_a: assert property (
		wr && ext && sel == debug_claim_lock_pkg::SEL_CLAIM_CLEAR
		|=> o_claim_tags == ($past(o_claim_tags) & ~$past(i_pwdata[NUM_CLAIMS-1:0])))
		else $error("external claim clear did not clear the written ones");

	claim_zero_write_a: assert property (
		wr && is_protected(sel) && i_pwdata[NUM_CLAIMS-1:0] == '0
		|=> $stable(o_claim_tags))
		else $error("zero claim write changed a tag");

	tags_idle_hold_a: assert property (
		!wr |=> $stable(o_claim_tags))
		else $error("claim tags changed with no write");

	ext_not_dropped_a: assert property (
		wr && ext && is_protected(sel) |=> !o_write_dropped)
		else $error("external claim write reported as dropped");

	drop_only_locked_a: assert property (
		!(o_locked && !ext && wr && is_protected(sel)) |=> !o_write_dropped)
		else $error("dropped write reported without a locked write");

	lock_only_by_key_a: assert property (
		!(wr && sel == debug_claim_lock_pkg::SEL_LOCK_KEY) |=> $stable(o_locked))
		else $error("lock changed without a key write");

	dbg_reset_claims_a: assert property (@(posedge i_clk) disable iff (1'b0)
		i_dbg_srst |=> o_claim_tags == '0)
		else $error("debug reset did not clear the claim tags");

	core_reset_claims_a: assert property (@(posedge i_clk) disable iff (1'b0)
		i_srst |=> o_claim_tags == '0)
		else $error("core reset did not clear the claim tags");

	unmapped_read_zero_a: assert property (
		rd_setup && sel == debug_claim_lock_pkg::SEL_NONE |=> o_prdata == '0)
		else $error("unmapped offset read not zero");

	key_read_zero_a: assert property (
		rd_setup && sel == debug_claim_lock_pkg::SEL_LOCK_KEY |=> o_prdata == '0)
		else $error("lock key read not zero");

	prdata_cleared_a: assert property (
		access |=> o_prdata == '0)
		else $error("read data still shown after the access phase");

endmodule : debug_claim_and_lock_regs

// [verif/apb_debug_master.sv]
// APB master standing for the debugger or debug software on the register port
// assumes zero or more wait states; signals change 1 ns after the rising edge
`include "debug_claim_lock_cfg.svh"

module apb_debug_master (
	input  wire logic        i_clk,
	input  wire logic        i_pready,
	input  wire logic [31:0] i_prdata,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [31:0] o_paddr,
	output logic      [31:0] o_pwdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = 32'h00000000;
		o_pwdata  = 32'h00000000;
	end

	// ==========================================================
	// one whole transfer; request held until pready is seen high or 16 access cycles pass
	task automatic xfer(input logic wr, input logic ext, input logic [11:0] ofs,
			input logic [31:0] wdata, output logic [31:0] rdata);
		int n;
		n = 0;
		// an external master never writes the lock key
		if (wr && ext && ofs == `DCL_OFS_LOCK_KEY) begin
			rdata = 32'h00000000;
			return;
		end
		// reserved claim bits go out as zero
		if (ofs == `DCL_OFS_CLAIM_SET || ofs == `DCL_OFS_CLAIM_CLEAR) begin
			wdata[31:8] = 24'h000000;
		end
		@(posedge i_clk);
		#1;
		o_psel   = 1'b1;
		o_pwrite = wr;
		o_paddr  = {ext, 19'h00000, ofs};
		o_pwdata = wdata;
		@(posedge i_clk);
		#1;
		o_penable = 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 16);
		rdata = (n < 16) ? i_prdata : 32'hxxxxxxxx;
		#1;
		// released lines show the inverse so stale values are never trusted
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_paddr   = ~o_paddr;
		o_pwdata  = ~o_pwdata;
	endtask : xfer

endmodule : apb_debug_master

// [verif/testbench.sv]
// self-checking bench for the claim tag and lock register block
// assumes the constants header is on the include path
`include "debug_claim_lock_cfg.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        dbg_srst = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, locked, dropped;
	logic [31:0] paddr, pwdata, prdata;
	logic [7:0]  tags;
	int          fails = 0;
	int          num_checks = 0;

	always #5 clk = ~clk;

	apb_debug_master master (.i_clk(clk), .i_pready(pready), .i_prdata(prdata), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

	debug_claim_and_lock_regs #(.NUM_CLAIMS(8)) i_debug_claim_and_lock_regs (
		.i_clk(clk), .i_srst(srst), .i_dbg_srst(dbg_srst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_claim_tags(tags), .o_locked(locked),
		.o_write_dropped(dropped));

	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic ext, input logic [11:0] ofs, input logic [31:0] d);
		logic [31:0] r;
		master.xfer(1'b1, ext, ofs, d, r);
	endtask : wr

	task automatic rd(input logic ext, input logic [11:0] ofs, input logic [31:0] exp, input string what);
		logic [31:0] r;
		master.xfer(1'b0, ext, ofs, 32'h00000000, r);
		check(what, exp, r);
		check("pslverr", 32'h0, {31'h0, pslverr});
		check("pready", 32'h1, {31'h0, pready});
	endtask : rd

	task automatic state(input logic [7:0] t, input logic l, input logic d);
		check("claim_tags", {24'h0, t}, {24'h0, tags});
		check("locked", {31'h0, l}, {31'h0, locked});
		check("write_dropped", {31'h0, d}, {31'h0, dropped});
	endtask : state

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// scenarios
	task automatic test_reset_values;
		state(8'h00, 1'b1, 1'b0);
		rd(1'b0, `DCL_OFS_LOCK_STATUS, 32'h00000003, "lock_status locked");
		rd(1'b0, `DCL_OFS_CLAIM_SET, 32'h000000ff, "claim_tag_set");
		rd(1'b0, `DCL_OFS_LOCK_KEY, 32'h00000000, "lock_key_access");
		rd(1'b0, 12'hf00, 32'h00000000, "unmapped");
		$display("test reset values done");
	endtask : test_reset_values

	task automatic test_locked_writes;
		wr(1'b0, `DCL_OFS_CLAIM_SET, 32'h000000ff);
		state(8'h00, 1'b1, 1'b1);
		wr(1'b1, `DCL_OFS_CLAIM_SET, 32'h00000080);
		state(8'h80, 1'b1, 1'b0);
		rd(1'b1, `DCL_OFS_LOCK_STATUS, 32'h00000000, "lock_status external");
		wr(1'b1, `DCL_OFS_CLAIM_CLEAR, 32'h00000080);
		state(8'h00, 1'b1, 1'b0);
		$display("test locked writes done");
	endtask : test_locked_writes

	task automatic test_claims;
		wr(1'b0, `DCL_OFS_LOCK_KEY, `DCL_UNLOCK_KEY);
		state(8'h00, 1'b0, 1'b0);
		wr(1'b0, `DCL_OFS_CLAIM_SET, 32'h00000005);
		wr(1'b0, `DCL_OFS_CLAIM_SET, 32'h0000000a);
		state(8'h0f, 1'b0, 1'b0);
		rd(1'b0, `DCL_OFS_LOCK_STATUS, 32'h00000001, "lock_status open");
		rd(1'b0, `DCL_OFS_CLAIM_CLEAR, 32'h0000000f, "claim_tag_clear");
		rd(1'b0, `DCL_OFS_CLAIM_SET, 32'h000000ff, "claim_tag_set");
		wr(1'b0, `DCL_OFS_CLAIM_CLEAR, 32'h00000003);
		wr(1'b0, `DCL_OFS_CLAIM_CLEAR, 32'h00000000);
		state(8'h0c, 1'b0, 1'b0);
		rd(1'b0, `DCL_OFS_CLAIM_CLEAR, 32'h0000000c, "claim_tag_clear");
		$display("test claims done");
	endtask : test_claims

	task automatic test_relock;
		wr(1'b0, `DCL_OFS_LOCK_KEY, `DCL_UNLOCK_KEY ^ 32'h00000001);
		state(8'h0c, 1'b1, 1'b0);
		wr(1'b0, `DCL_OFS_CLAIM_CLEAR, 32'h000000ff);
		state(8'h0c, 1'b1, 1'b1);
		wr(1'b0, `DCL_OFS_LOCK_KEY, `DCL_UNLOCK_KEY);
		state(8'h0c, 1'b0, 1'b0);
		rd(1'b0, `DCL_OFS_LOCK_STATUS, 32'h00000001, "lock_status reopened");
		$display("test relock done");
	endtask : test_relock

	task automatic test_resets;
		@(posedge clk);
		#1;
		srst = 1'b1;
		@(posedge clk);
		#1;
		srst = 1'b0;
		state(8'h00, 1'b0, 1'b0);
		@(posedge clk);
		#1;
		dbg_srst = 1'b1;
		@(posedge clk);
		#1;
		dbg_srst = 1'b0;
		state(8'h00, 1'b1, 1'b0);
		rd(1'b0, `DCL_OFS_LOCK_STATUS, 32'h00000003, "lock_status after reset");
		$display("test resets done");
	endtask : test_resets

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (6) @(posedge clk);
		#1;
		srst     = 1'b0;
		dbg_srst = 1'b0;
		test_reset_values();
		test_locked_writes();
		test_claims();
		test_relock();
		test_resets();
		stop_test();
	end

	// whole run is under a hundred cycles; allow ample margin
	initial begin
		#50000;
		fails++;
		stop_test();
	end

endmodule : testbench
